// ### hdl/hdr_scramble_pkg.sv
package hdr_scramble_pkg;

    // Header geometry per bandplan group
    localparam int NARROW_BITS    = 42;
    localparam int WIDE_BITS      = 74;
    localparam int HDR_CNT_W      = 7;
    localparam int CHECK_BITS     = 12;
    localparam int TONE_NARROW_W  = 8;
    localparam int TONE_WIDE_W    = 40;
    localparam int DUR_NARROW_W   = 7;
    localparam int DUR_WIDE_W     = 10;

    // Field positions, narrow plan
    localparam int N_TYPE_LSB     = 0;
    localparam int N_LEN_LSB      = 2;
    localparam int N_TONE_LSB     = 10;
    localparam int N_BSEL_POS     = 18;
    localparam int N_RATE_POS     = 19;
    localparam int N_REP_LSB      = 20;
    localparam int N_ILV_POS      = 23;
    localparam int N_MOD_LSB      = 24;
    localparam int N_REPLY_LSB    = 26;
    localparam int N_CHECK_LSB    = 30;
    localparam int N_DUR_LSB      = 2;

    // Field positions, wide plan
    localparam int W_TONE_LSB     = 10;
    localparam int W_BSEL_POS     = 50;
    localparam int W_RATE_POS     = 51;
    localparam int W_REP_LSB      = 52;
    localparam int W_ILV_POS      = 55;
    localparam int W_MOD_LSB      = 56;
    localparam int W_REPLY_LSB    = 58;
    localparam int W_CHECK_LSB    = 62;
    localparam int W_DUR_LSB      = 2;

    // Scrambler seed
    localparam logic [6:0] LFSR_SEED = 7'h7F;

    // Segmentation constants
    localparam logic [15:0] FIRST_BLOCK_BYTES = 16'h0010;
    localparam int          TAIL_BITS         = 6;
    localparam logic [2:0]  TAIL_CNT_LAST     = 3'h5;

    // Frame type codes
    localparam logic [1:0] FT_DATA  = 2'h1;
    localparam logic [1:0] FT_DUR_A = 2'h2;
    localparam logic [1:0] FT_NODUR = 2'h3;
    localparam logic [1:0] FT_DUR_B = 2'h0;

    // Reply request codes
    localparam logic [1:0] REPLY_NONE = 2'h0;
    localparam logic [1:0] REPLY_REG  = 2'h2;
    localparam logic [1:0] REPLY_EXT  = 2'h1;
    localparam logic [1:0] REPLY_RSVD = 2'h3;

    // Interleave mode codes
    localparam logic ILV_FRAGMENT = 1'b0;
    localparam logic ILV_ALL_CW   = 1'b1;

    typedef enum logic [1:0] {
        MOD_1BIT = 2'h0,
        MOD_2BIT = 2'h1,
        MOD_3BIT = 2'h2,
        MOD_4BIT = 2'h3
    } mod_e;

    // Header field values as handed over by the MAC side
    typedef struct packed {
        logic [1:0]  frame_type_field;
        logic [7:0]  payload_length_code;
        logic [39:0] tone_group_mask;
        logic        block_size_select;
        logic        inner_code_rate_select;
        logic [2:0]  repeat_count_code;
        logic        interleave_mode_flag;
        mod_e        modulation;
        logic [1:0]  reply_request;
        logic [9:0]  sequence_duration_field;
        logic [11:0] header_check_sequence;
    } hdr_fields_s;

    // One scrambled output bit with its position markers
    typedef struct packed {
        logic data;
        logic hdr;
        logic blk_end;
        logic last;
    } out_bit_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HDR,
        PH_PAY,
        PH_TAIL
    } phase_e;

endpackage

// ### hdl/plc_phy_header_scramble_segmenter.sv
`timescale 1ns/10ps
module plc_phy_header_scramble_segmenter
    import hdr_scramble_pkg::*;
(
    // Clock and reset
    input  wire logic                          CORE_CLK_IN,
    input  wire logic                          RST_N_IN,
    // Transmit request
    input  wire logic                          REQ_VALID_IN,
    output wire logic                          REQ_READY_OUT,
    input  wire logic                          WIDE_PLAN_IN,
    input  wire hdr_scramble_pkg::hdr_fields_s HDR_FIELDS_IN,
    input  wire logic [15:0]                   PAYLOAD_BYTES_IN,
    input  wire logic [7:0]                    BLOCK_COUNT_IN,
    // Payload byte stream
    input  wire logic                          PAY_VALID_IN,
    output wire logic                          PAY_READY_OUT,
    input  wire logic [7:0]                    PAY_DATA_IN,
    // Scrambled bit stream
    output wire logic                          BIT_VALID_OUT,
    input  wire logic                          BIT_READY_IN,
    output wire hdr_scramble_pkg::out_bit_s    BIT_OUT,
    // Status
    output logic                               BUSY_OUT,
    output logic                               REPLY_ERR_OUT
);
    import hdr_scramble_pkg::*;

    // Block size of information block idx (1-based) for this frame
    function automatic logic [15:0] block_size(
        input logic [7:0]  idx,
        input logic [7:0]  m1,
        input logic [15:0] kl
    );
        if (idx == 8'h01) begin
            block_size = FIRST_BLOCK_BYTES;
        end else if ({8'h00, idx - 8'h01} <= {8'h00, m1}) begin
            block_size = kl;
        end else begin
            block_size = kl - 16'h0001;
        end
    endfunction

    phase_e           phase_reg,   phase_next;
    logic [73:0]      hdr_reg;
    logic [6:0]       hdr_cnt_reg;
    logic [6:0]       hdr_last_reg;
    logic [6:0]       lfsr_reg;
    logic [7:0]       byte_reg;
    logic [2:0]       bit_cnt_reg;
    logic             byte_full_reg;
    logic [15:0]      blk_left_reg;
    logic [7:0]       blk_idx_reg;
    logic [7:0]       blk_total_reg;
    logic [7:0]       m1_reg;
    logic [15:0]      kl_reg;
    logic [2:0]       tail_cnt_reg;

    // Two-entry output buffer
    out_bit_s         buf_mem [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;

    // Header image built from the fields, reserved bits left zero
    logic [73:0]      hdr_img;
    hdr_fields_s      f;
    assign f = HDR_FIELDS_IN;

    always_comb begin
        hdr_img = '0;
        hdr_img[1:0] = f.frame_type_field;
        if (f.frame_type_field == FT_DATA && !WIDE_PLAN_IN) begin
            hdr_img[N_LEN_LSB +: 8]   = f.payload_length_code;
            hdr_img[N_TONE_LSB +: TONE_NARROW_W] =
                f.tone_group_mask[TONE_NARROW_W-1:0];
            hdr_img[N_BSEL_POS]       = f.block_size_select;
            hdr_img[N_RATE_POS]       = f.inner_code_rate_select;
            hdr_img[N_REP_LSB +: 3]   = f.repeat_count_code;
            hdr_img[N_ILV_POS]        = f.interleave_mode_flag;
            hdr_img[N_MOD_LSB +: 2]   = f.modulation;
            hdr_img[N_REPLY_LSB +: 2] = f.reply_request;
        end else if (f.frame_type_field == FT_DATA) begin
            hdr_img[N_LEN_LSB +: 8]   = f.payload_length_code;
            hdr_img[W_TONE_LSB +: TONE_WIDE_W] = f.tone_group_mask;
            hdr_img[W_BSEL_POS]       = f.block_size_select;
            hdr_img[W_RATE_POS]       = f.inner_code_rate_select;
            hdr_img[W_REP_LSB +: 3]   = f.repeat_count_code;
            hdr_img[W_ILV_POS]        = f.interleave_mode_flag;
            hdr_img[W_MOD_LSB +: 2]   = f.modulation;
            hdr_img[W_REPLY_LSB +: 2] = f.reply_request;
        end else if (f.frame_type_field != FT_NODUR) begin
            if (WIDE_PLAN_IN) begin
                hdr_img[W_DUR_LSB +: DUR_WIDE_W] =
                    f.sequence_duration_field;
            end else begin
                hdr_img[N_DUR_LSB +: DUR_NARROW_W] =
                    f.sequence_duration_field[DUR_NARROW_W-1:0];
            end
        end
        // Type 3 keeps everything but type and check at zero
        if (WIDE_PLAN_IN) begin
            hdr_img[W_CHECK_LSB +: CHECK_BITS] = f.header_check_sequence;
        end else begin
            hdr_img[N_CHECK_LSB +: CHECK_BITS] = f.header_check_sequence;
        end
    end

    // Segmentation arithmetic, divisor m-1 taken as at least one
    logic [15:0] rest_bytes;
    logic [15:0] div_m;
    logic [15:0] kl_calc;
    logic [15:0] m1_calc;
    assign rest_bytes = PAYLOAD_BYTES_IN - FIRST_BLOCK_BYTES;
    assign div_m      = (BLOCK_COUNT_IN > 8'h01) ?
                        {8'h00, BLOCK_COUNT_IN - 8'h01} : 16'h0001;
    assign kl_calc    = rest_bytes / div_m + 16'h0001;
    assign m1_calc    = rest_bytes % div_m;

    // Request handshake and reply-code guard
    logic req_fire;
    logic reply_bad;
    assign reply_bad     = f.frame_type_field == FT_DATA &&
                           f.reply_request == REPLY_RSVD;
    assign REQ_READY_OUT = phase_reg == PH_IDLE;
    assign req_fire      = REQ_VALID_IN && REQ_READY_OUT && !reply_bad;

    // Bit production and buffer handshake
    logic     buf_ready;
    logic     bit_take;
    logic     raw_bit;
    logic     produce;
    logic     pay_take;
    logic     blk_done;
    logic     lfsr_out;
    out_bit_s new_bit;
    assign buf_ready = count_reg != 2'h2;
    assign lfsr_out  = lfsr_reg[6] ^ lfsr_reg[3];
    assign pay_take  = PAY_VALID_IN && PAY_READY_OUT;
    assign PAY_READY_OUT = phase_reg == PH_PAY && !byte_full_reg;
    assign produce   = buf_ready && ((phase_reg == PH_HDR) ||
                       (phase_reg == PH_PAY && byte_full_reg) ||
                       (phase_reg == PH_TAIL));
    assign raw_bit   = (phase_reg == PH_HDR) ? hdr_reg[0] :
                       (phase_reg == PH_PAY) ? byte_reg[0] : 1'b0;
    assign blk_done  = phase_reg == PH_PAY && bit_cnt_reg == 3'h7 &&
                       blk_left_reg == 16'h0001;
    assign new_bit.data    = raw_bit ^ lfsr_out;
    assign new_bit.hdr     = phase_reg == PH_HDR;
    assign new_bit.blk_end = blk_done ||
                             (phase_reg == PH_HDR &&
                              hdr_cnt_reg == hdr_last_reg);
    assign new_bit.last    = phase_reg == PH_TAIL &&
                             tail_cnt_reg == TAIL_CNT_LAST;

    // Phase sequencing
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_IDLE: if (req_fire) phase_next = PH_HDR;
            PH_HDR:  if (produce && hdr_cnt_reg == hdr_last_reg)
                         phase_next = PH_PAY;
            PH_PAY:  if (produce && blk_done &&
                         blk_idx_reg == blk_total_reg)
                         phase_next = PH_TAIL;
            PH_TAIL: if (produce && tail_cnt_reg == TAIL_CNT_LAST)
                         phase_next = PH_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Header shift register, bit 0 first
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            hdr_reg      <= '0;
            hdr_cnt_reg  <= '0;
            hdr_last_reg <= '0;
        end else if (req_fire) begin
            hdr_reg      <= hdr_img;
            hdr_cnt_reg  <= '0;
            hdr_last_reg <= WIDE_PLAN_IN ? 7'(WIDE_BITS - 1) :
                                           7'(NARROW_BITS - 1);
        end else if (produce && phase_reg == PH_HDR) begin
            hdr_reg     <= {1'b0, hdr_reg[73:1]};
            hdr_cnt_reg <= hdr_cnt_reg + 7'h01;
        end
    end

    // Scrambler: seeded at request, reseeded after last header bit
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            lfsr_reg <= LFSR_SEED;
        end else if (req_fire) begin
            lfsr_reg <= LFSR_SEED;
        end else if (produce && phase_reg == PH_HDR &&
                     hdr_cnt_reg == hdr_last_reg) begin
            lfsr_reg <= LFSR_SEED;
        end else if (produce) begin
            lfsr_reg <= {lfsr_reg[5:0], lfsr_out};
        end
    end

    // Payload byte holder, LSB first, and block bookkeeping
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            byte_reg      <= '0;
            bit_cnt_reg   <= '0;
            byte_full_reg <= 1'b0;
            blk_left_reg  <= '0;
            blk_idx_reg   <= '0;
            blk_total_reg <= '0;
            m1_reg        <= '0;
            kl_reg        <= '0;
            tail_cnt_reg  <= '0;
        end else if (req_fire) begin
            blk_total_reg <= BLOCK_COUNT_IN;
            m1_reg        <= m1_calc[7:0];
            kl_reg        <= kl_calc;
            blk_idx_reg   <= 8'h01;
            blk_left_reg  <= FIRST_BLOCK_BYTES;
            tail_cnt_reg  <= '0;
            byte_full_reg <= 1'b0;
            bit_cnt_reg   <= '0;
        end else begin
            if (pay_take) begin
                byte_reg      <= PAY_DATA_IN;
                byte_full_reg <= 1'b1;
                bit_cnt_reg   <= '0;
            end else if (produce && phase_reg == PH_PAY) begin
                byte_reg    <= {1'b0, byte_reg[7:1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_full_reg <= 1'b0;
                    if (blk_left_reg == 16'h0001) begin
                        blk_idx_reg  <= blk_idx_reg + 8'h01;
                        blk_left_reg <= block_size(blk_idx_reg + 8'h01,
                                                   m1_reg, kl_reg);
                    end else begin
                        blk_left_reg <= blk_left_reg - 16'h0001;
                    end
                end
            end
            if (produce && phase_reg == PH_TAIL) begin
                tail_cnt_reg <= tail_cnt_reg + 3'h1;
            end
        end
    end

    // Two-entry buffer so a receiver stall loses no bit
    assign bit_take      = BIT_VALID_OUT && BIT_READY_IN;
    assign BIT_VALID_OUT = count_reg != 2'h0;
    assign BIT_OUT       = buf_mem[rd_ptr_reg];

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (produce) begin
                buf_mem[wr_ptr_reg] <= new_bit;
                wr_ptr_reg          <= !wr_ptr_reg;
            end
            if (bit_take) begin
                rd_ptr_reg <= !rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, produce} - {1'b0, bit_take};
        end
    end

    // Status flags
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            BUSY_OUT      <= 1'b0;
            REPLY_ERR_OUT <= 1'b0;
        end else begin
            BUSY_OUT      <= phase_next != PH_IDLE;
            REPLY_ERR_OUT <= REQ_VALID_IN && REQ_READY_OUT && reply_bad;
        end
    end

    // Checks
    a_seed_at_start: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN) req_fire |=> lfsr_reg == LFSR_SEED)
        else $error("scrambler not seeded at request");
    a_reseed_payload: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        $rose(phase_reg == PH_PAY) |-> lfsr_reg == LFSR_SEED)
        else $error("scrambler not reseeded for payload");
    a_lfsr_step: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        produce && phase_reg == PH_PAY |=>
        lfsr_reg[6:1] == $past(lfsr_reg[5:0]))
        else $error("scrambler did not step");
    a_reply_reserved: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        REQ_VALID_IN && REQ_READY_OUT && reply_bad |=>
        REPLY_ERR_OUT && phase_reg == PH_IDLE)
        else $error("reserved reply code accepted");
    a_first_block: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        req_fire |=> blk_left_reg == FIRST_BLOCK_BYTES &&
        blk_idx_reg == 8'h01)
        else $error("first block not sixteen bytes");
    a_tail_zero: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN) phase_reg == PH_TAIL |-> !raw_bit)
        else $error("tail bit not zero");
    a_tail_len: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        $rose(phase_reg == PH_TAIL) |-> phase_reg == PH_TAIL [*6])
        else $error("tail shorter than six bits");
    a_hdr_order: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        produce && phase_reg == PH_HDR && hdr_cnt_reg != hdr_last_reg
        |=> hdr_cnt_reg == $past(hdr_cnt_reg) + 7'h01)
        else $error("header bit order broken");
    a_buf_bound: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        count_reg != 2'h3 && !(count_reg == 2'h2 && produce))
        else $error("output buffer overrun");
    a_rsvd_zero: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RST_N_IN)
        req_fire && f.frame_type_field == FT_NODUR && !WIDE_PLAN_IN
        |=> hdr_reg[29:2] == '0)
        else $error("reserved header bits not zero");

endmodule

// ### dv/mac_byte_source.sv
`timescale 1ns/10ps
// MAC side payload source: offers bytes in order, optionally with gaps
module mac_byte_source (
    // Clock, reset, frame restart, pacing and byte count
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        start_in,
    input  wire logic        slow_in,
    input  wire logic [15:0] total_in,
    // Byte stream
    output logic             valid_out,
    input  wire logic        ready_in,
    output logic [7:0]       data_out
);
    logic        took = 1'b0;
    logic        hold = 1'b1;
    logic [15:0] idx = 16'h0000;

    initial valid_out = 1'b0;
    initial data_out = 8'h00;

    // Byte content derived from its position in the unit
    function automatic logic [7:0] pat(input logic [15:0] i);
        return i[7:0] * 8'h25 + 8'h3C;
    endfunction

    // Sampled on the rising edge so negedge drive never races the bench
    always @(posedge clk_in) begin
        took <= valid_out && ready_in;
        hold <= !rst_n_in || start_in;
    end

    // Byte held until taken; invalid data keeps toggling except while hold is set
    always @(negedge clk_in) begin
        if (hold) begin
            idx = 16'h0000;
            valid_out = 1'b0;
        end else begin
            if (took)
                idx = idx + 16'h0001;
            if (idx < total_in && !(slow_in && took)) begin
                valid_out = 1'b1;
                data_out = pat(idx);
            end else begin
                valid_out = 1'b0;
                data_out = ~data_out;
            end
        end
    end
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t exp=%0h got=%0h", $time, (b), (a)); end end
module testbench;
    import hdr_scramble_pkg::*;
    localparam int LIMIT = 40000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_ready;
    logic        wide = 1'b0;
    hdr_fields_s fields = '0;
    logic [15:0] n_bytes = 16'h0010;
    logic [7:0]  m_blocks = 8'h01;
    logic        pay_valid;
    logic        pay_ready;
    logic [7:0]  pay_data;
    logic        bit_valid;
    logic        bit_ready = 1'b1;
    out_bit_s    bit_out;
    logic        busy;
    logic        reply_err;
    logic        src_start = 1'b0;
    logic        src_slow = 1'b0;
    int          sink_mode = 0;
    out_bit_s    exp_q[$];
    out_bit_s    e;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          sink_cnt = 0;
    logic [1:0]  ft_tab[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0]  reply_tab[3] = '{2'h0, 2'h2, 2'h1};

    always #20 clk = ~clk;

    plc_phy_header_scramble_segmenter DUT (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(req_valid),
        .REQ_READY_OUT(req_ready), .WIDE_PLAN_IN(wide),
        .HDR_FIELDS_IN(fields), .PAYLOAD_BYTES_IN(n_bytes),
        .BLOCK_COUNT_IN(m_blocks), .PAY_VALID_IN(pay_valid),
        .PAY_READY_OUT(pay_ready), .PAY_DATA_IN(pay_data),
        .BIT_VALID_OUT(bit_valid), .BIT_READY_IN(bit_ready),
        .BIT_OUT(bit_out), .BUSY_OUT(busy), .REPLY_ERR_OUT(reply_err));

    mac_byte_source src (
        .clk_in(clk), .rst_n_in(rst_n), .start_in(src_start),
        .slow_in(src_slow), .total_in(n_bytes), .valid_out(pay_valid),
        .ready_in(pay_ready), .data_out(pay_data));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    // Sink: ready set here, so a bit seen valid now is taken next edge
    always @(negedge clk) begin
        sink_cnt++;
        bit_ready = sink_mode == 0 || (sink_mode == 1 && sink_cnt % 16 >= 10);
        if (bit_valid && bit_ready) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : out_bit_s'(4'hX);
            `CHK(bit_out, e)
        end
    end

    function automatic hdr_fields_s mk(input logic [1:0] ft, input int i);
        hdr_fields_s f;
        f.frame_type_field = ft;
        f.payload_length_code = 8'hC5 ^ 8'(i);
        f.tone_group_mask = 40'h96A53CE17B;
        f.block_size_select = i[0];
        f.inner_code_rate_select = ~i[0];
        f.repeat_count_code = 3'(i);
        f.interleave_mode_flag = i[0];
        f.modulation = mod_e'(i[1:0]);
        f.reply_request = reply_tab[i % 3];
        f.sequence_duration_field = 10'h2D9 ^ 10'(i);
        f.header_check_sequence = 12'hB4E ^ 12'(i);
        return f;
    endfunction

    function automatic logic [73:0] pack_hdr(hdr_fields_s f, logic w);
        logic [9:0]  mid;
        logic [11:0] c;
        mid = {f.reply_request, f.modulation, f.interleave_mode_flag,
               f.repeat_count_code, f.inner_code_rate_select,
               f.block_size_select};
        c = f.header_check_sequence;
        case (f.frame_type_field)
            2'h1: return w ? {c, 2'h0, mid, f.tone_group_mask,
                    f.payload_length_code, 2'h1} : {32'h0, c, 2'h0, mid,
                    f.tone_group_mask[7:0], f.payload_length_code, 2'h1};
            2'h3: return w ? {c, 60'h0, 2'h3} : {32'h0, c, 28'h0, 2'h3};
            default: return w ? {c, 50'h0, f.sequence_duration_field,
                    f.frame_type_field} : {32'h0, c, 21'h0,
                    f.sequence_duration_field[6:0], f.frame_type_field};
        endcase
    endfunction

    // One scrambler step: output bit, then shift it in
    function automatic logic step(inout logic [6:0] s);
        logic o;
        o = s[6] ^ s[3];
        s = {s[5:0], o};
        return o;
    endfunction

    task automatic expect_frame(hdr_fields_s f, logic w, int n, int m);
        logic [6:0]  s;
        logic [73:0] h;
        logic [7:0]  by;
        int          hb;
        int          idx;
        int          blk[$];
        h = pack_hdr(f, w);
        hb = w ? 74 : 42;
        s = 7'h7F;
        for (int b = 0; b < hb; b++)
            exp_q.push_back({h[b] ^ step(s), 1'b1, b == hb - 1, 1'b0});
        blk.push_back(16);
        for (int k = 1; k < m; k++)
            blk.push_back((n - 16) / (m - 1) + (k <= (n - 16) % (m - 1)));
        s = 7'h7F;
        idx = 0;
        foreach (blk[k])
            for (int j = 0; j < blk[k]; j++) begin
                by = src.pat(16'(idx));
                idx++;
                for (int t = 0; t < 8; t++)
                    exp_q.push_back({by[t] ^ step(s), 1'b0,
                                     j == blk[k] - 1 && t == 7, 1'b0});
            end
        for (int t = 0; t < TAIL_BITS; t++)
            exp_q.push_back({step(s), 1'b0, 1'b0, t == TAIL_BITS - 1});
    endtask

    task automatic run_frame(hdr_fields_s f, logic w, int n, int m, string nm);
        int lat;
        expect_frame(f, w, n, m);
        @(negedge clk);
        src_start = 1'b1;
        @(negedge clk);
        src_start = 1'b0;
        `CHK(req_ready, 1'b1)
        fields = f;
        wide = w;
        n_bytes = 16'(n);
        m_blocks = 8'(m);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        `CHK(busy, 1'b1)
        lat = 0;
        while (!bit_valid && lat < 10) begin
            @(negedge clk);
            lat++;
        end
        `CHK(lat <= 2, 1'b1)
        lat = 0;
        while ((exp_q.size() > 0 || busy !== 1'b0) && lat < 9000) begin
            @(negedge clk);
            lat++;
        end
        `CHK(exp_q.size(), 0)
        // Last bit may still sit in the buffer until the next edge
        @(negedge clk);
        `CHK(bit_valid, 1'b0)
        $display("test %s done", nm);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        `CHK({req_ready, bit_valid, busy, reply_err}, 4'h8)
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++)
            run_frame(mk(2'h1, i), i[0], 16, 1, "type1");
        for (int i = 1; i < 4; i++)
            for (int w = 0; w < 2; w++)
                run_frame(mk(ft_tab[i], i + w), w[0], 16, 1, "no_len");
        src_slow = 1'b1;
        sink_mode = 1;
        run_frame(mk(2'h1, 5), 1'b0, 23, 3, "seg_rem");
        run_frame(mk(2'h2, 6), 1'b1, 22, 4, "seg_even");
        src_slow = 1'b0;
        run_frame(mk(2'h3, 7), 1'b0, 40, 2, "seg_two");
        sink_mode = 0;
        // Reserved reply code is refused while idle
        fields = mk(2'h1, 0);
        fields.reply_request = 2'h3;
        req_valid = 1'b1;
        repeat (3) begin
            @(negedge clk);
            `CHK({reply_err, busy}, 2'h2)
        end
        req_valid = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(reply_err, 1'b0)
        $display("test refuse done");
        // Reset in mid-frame, then a clean frame
        sink_mode = 2;
        fields = mk(2'h1, 1);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (30) @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({req_ready, bit_valid, busy}, 3'h4)
        $display("test mid_reset done");
        rst_n = 1'b1;
        sink_mode = 0;
        run_frame(mk(2'h1, 3), 1'b1, 16, 1, "after_reset");
        finish_test();
    end
endmodule
